// >>> flash_host.v
// Host controller that reads and sector-programs the parallel flash.
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_host
#(
  parameter PROG_CYC = `PROG_TIME_CYC,
  parameter GAP_CYC = `LOAD_GAP_CYC
)
(
  input wire i_clock,
  input wire i_reset,
  input wire i_req,
  input wire [1:0] i_cmd,
  input wire [15:0] i_addr,
  input wire i_protect,
  input wire [7:0] i_wdata,
  input wire i_wvalid,
  input wire [7:0] i_data_pins,
  output reg o_busy,
  output reg o_wready,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  output reg o_timeout,
  output wire o_ce_n,
  output wire o_oe_n,
  output wire o_we_n,
  output wire [15:0] o_addr_lines,
  output wire [7:0] o_data_pins,
  output wire o_data_pins_oe
);

localparam H_IDLE = 8'h01;
localparam H_READ = 8'h02;
localparam H_PREFIX = 8'h04;
localparam H_LOAD = 8'h08;
localparam H_GAP = 8'h10;
localparam H_SETTLE = 8'h20;
localparam H_POLL = 8'h40;
localparam H_RDWAIT = 8'h80;

reg [7:0] state_q;
reg [1:0] cmd_q;
reg [15:0] base_q;
reg [7:0] last_q;
reg [6:0] last_off_q;
reg [7:0] nbytes_q;
reg [1:0] pfx_q;
reg [31:0] tmr_q;
reg st_start;
reg st_write;
reg [15:0] st_addr;
reg [7:0] st_wdata;
wire [7:0] st_rdata;
wire st_done;
reg [23:0] pfx_word;

// Fixed address and data of each command-prefix write.
function [23:0] prefix_word;
  input [1:0] idx;
  input dis;
  begin
    case (idx)
      2'h0: prefix_word = {`PROT_ADDR0, `PROT_DATA_EN0}; // R26
      2'h1: prefix_word = {`PROT_ADDR1, `PROT_DATA_EN1}; // R26
      default: prefix_word = {`PROT_ADDR0,
        (dis ? `PROT_DATA_DIS2 : `PROT_DATA_EN2)}; // R26
    endcase
  end
endfunction

always @*
  pfx_word = prefix_word(pfx_q, cmd_q == `CMD_DISABLE);

flash_strobe u_strobe
(
  .i_clock(i_clock),
  .i_reset(i_reset),
  .i_start(st_start),
  .i_write(st_write),
  .i_addr(st_addr),
  .i_wdata(st_wdata),
  .i_data_pins(i_data_pins),
  .o_ce_n(o_ce_n),
  .o_oe_n(o_oe_n),
  .o_we_n(o_we_n),
  .o_addr_lines(o_addr_lines),
  .o_data_pins(o_data_pins),
  .o_data_pins_oe(o_data_pins_oe),
  .o_rdata(st_rdata),
  .o_done(st_done)
);

////////////////////////////////////////////////////////////////////////////////
// Every command write leaves a short fixed gap and each byte load at least one
// cycle more, far below the device timeout; a slow byte source ends the sector
// early, so the user must keep bytes flowing.
always @(posedge i_clock or posedge i_reset)
begin
  if (i_reset)
  begin
    state_q <= H_IDLE;
    cmd_q <= `CMD_READ;
    base_q <= 16'h0000;
    last_q <= 8'h00;
    last_off_q <= 7'h00;
    nbytes_q <= 8'h00;
    pfx_q <= 2'h0;
    tmr_q <= 32'h00000000;
    st_start <= 1'b0;
    st_write <= 1'b0;
    st_addr <= 16'h0000;
    st_wdata <= 8'h00;
    o_busy <= 1'b0;
    o_wready <= 1'b0;
    o_rdata <= 8'h00;
    o_rvalid <= 1'b0;
    o_timeout <= 1'b0;
  end
  else
  begin
    st_start <= 1'b0;
    o_rvalid <= 1'b0;
    o_wready <= 1'b0;
    case (state_q)
      H_IDLE:
      begin
        o_busy <= 1'b0;
        if (i_req)
        begin
          o_busy <= 1'b1;
          o_timeout <= 1'b0;
          cmd_q <= i_cmd;
          base_q <= {i_addr[15:`SECTOR_LSB], 7'h00}; // R11
          pfx_q <= 2'h0;
          nbytes_q <= 8'h00;
          if (i_cmd == `CMD_READ)
          begin
            st_start <= 1'b1;
            st_write <= 1'b0;
            st_addr <= i_addr; // R1
            state_q <= H_READ;
          end
          else if (i_cmd == `CMD_PROG && !i_protect)
            state_q <= H_LOAD;
          else
            state_q <= H_PREFIX; // R20 R21
        end
      end
      H_READ:
      begin
        if (st_done)
        begin
          o_rdata <= st_rdata; // R2
          o_rvalid <= 1'b1;
          o_busy <= 1'b0;
          state_q <= H_IDLE;
        end
      end
      H_PREFIX:
      begin
        // Command writes run through the same strobe engine as loads.
        if (!st_start && pfx_q != 2'h3)
        begin
          st_start <= 1'b1;
          st_write <= 1'b1;
          st_addr <= pfx_word[23:8]; // R22
          st_wdata <= pfx_word[7:0];
          pfx_q <= 2'h3;
          nbytes_q <= {6'h00, pfx_q};
          state_q <= H_GAP;
        end
      end
      H_LOAD:
      begin
        o_wready <= 1'b1;
        if (i_wvalid && o_wready)
        begin
          o_wready <= 1'b0;
          st_start <= 1'b1;
          st_write <= 1'b1;
          st_addr <= base_q | {9'h000, nbytes_q[6:0]}; // R12 R13
          st_wdata <= i_wdata;
          last_q <= i_wdata;
          last_off_q <= nbytes_q[6:0];
          nbytes_q <= nbytes_q + 8'h01; // R7
          state_q <= H_GAP;
        end
      end
      H_GAP:
      begin
        if (st_done)
        begin
          tmr_q <= 32'h00000000;
          if (pfx_q == 2'h3 && nbytes_q[1:0] != 2'h2)
          begin
            // More command writes of the prefix are still to go.
            pfx_q <= nbytes_q[1:0] + 2'h1;
            state_q <= H_PREFIX; // R20 R21
          end
          else if (pfx_q == 2'h3 && cmd_q != `CMD_PROG)
            state_q <= H_SETTLE; // R20 R23
          else if (pfx_q == 2'h3)
          begin
            // Prefix complete; the sector loads must follow inside the gap.
            pfx_q <= 2'h0;
            nbytes_q <= 8'h00;
            state_q <= H_LOAD; // R21
          end
          else if (nbytes_q == `SECTOR_BYTES)
            state_q <= H_SETTLE; // R7
          else
            state_q <= H_LOAD; // R9
        end
      end
      H_SETTLE:
      begin
        // Idle past the timeout so the device closes the window.
        tmr_q <= tmr_q + 32'h1;
        if (tmr_q == GAP_CYC + {16'h0000, `GAP_MARGIN_CYC}) // R10
        begin
          tmr_q <= 32'h00000000;
          state_q <= H_POLL;
        end
      end
      H_POLL:
      begin
        // Poll the last byte; top bit equal to the loaded byte's top bit means the cycle is over.
        st_start <= 1'b1;
        st_write <= 1'b0;
        st_addr <= base_q | {9'h000, last_off_q}; // R17
        state_q <= H_RDWAIT;
      end
      H_RDWAIT:
      begin
        tmr_q <= tmr_q + 32'h1;
        if (st_done)
        begin
          if (cmd_q != `CMD_PROG
            || st_rdata[`POLL_BIT] == last_q[`POLL_BIT]) // R16
          begin
            o_busy <= 1'b0;
            state_q <= H_IDLE;
          end
          else if (tmr_q > PROG_CYC) // R15
          begin
            o_timeout <= 1'b1;
            o_busy <= 1'b0;
            state_q <= H_IDLE;
          end
          else
            state_q <= H_POLL;
        end
      end
      default:
        state_q <= H_IDLE;
    endcase
  end
end

endmodule // flash_host

// >>> flash_host_map.vh
// Constants for the sector flash host controller.
// Contract
// R1 - Device holds 65,536 bytes, read with select and gate low, strobe high.
// R2 - Device drives the addressed byte only while read conditions hold.
// R3 - Device floats data pins when select or gate is high.
// R4 - Host loads a byte by pulsing strobe low, select low, gate high.
// R5 - Device latches address at the later falling edge of select/strobe.
// R6 - Device latches data at the earlier rising edge of select/strobe.
// R7 - Host loads all 128 bytes of a sector before programming starts.
// R8 - Unloaded sector bytes read as all ones after programming.
// R9 - Host starts each next load within 150 us of the previous rising edge.
// R10 - Device starts programming when no load follows within the timeout.
// R11 - Host holds the sector number on the upper nine address lines.
// R12 - Lowest seven address lines pick the byte within the sector.
// R13 - Device accepts sector bytes in any order.
// R14 - Device latches data, erases, programs on its own timer, bus free.
// R15 - Device finishes a sector cycle within the nominal program time.
// R16 - Completion shown on top data bit; host waits for it.
// R17 - Polling the last byte returns inverted top bit until done.
// R18 - Bit six toggles on each read while busy.
// R19 - Write protection starts disabled.
// R20 - Three command writes enter the protected state.
// R21 - When protected, every program cycle needs the three-command prefix.
// R22 - Command writes use the same strobe timing and timeout as loads.
// R23 - Protection persists and is cleared only by the disable sequence.
// R24 - Unprefixed write while protected runs the timer, changes nothing.
// R25 - Reads act as polling for the write cycle after a rejected write.
// R26 - Command addresses and data are implementation parameters.
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH

`define CLK_PERIOD_NS 5
`define LOAD_GAP_US 150
// Longest gap between a rising strobe and the next fall: 150 us in clock cycles.
`define LOAD_GAP_CYC ((`LOAD_GAP_US * 1000) / `CLK_PERIOD_NS)
`define GAP_MARGIN_CYC 16'h0100
`define PROG_TIME_MS 10
`define PROG_TIME_CYC ((`PROG_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define PHASE_CYC 8'h06
`define SECTOR_BYTES 8'h80
`define SECTOR_LSB 7
`define BYTE_W 7
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define PROT_ADDR0 16'h1111
`define PROT_ADDR1 16'h2222
`define PROT_DATA_EN0 8'h11
`define PROT_DATA_EN1 8'h22
`define PROT_DATA_EN2 8'h33
`define PROT_DATA_DIS2 8'h44
`define CMD_READ 2'h0
`define CMD_PROG 2'h1
`define CMD_ENABLE 2'h2
`define CMD_DISABLE 2'h3

`endif

// >>> flash_strobe.v
// One host bus cycle on the flash pins: read or byte load.
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_strobe
(
  input wire i_clock,
  input wire i_reset,
  input wire i_start,
  input wire i_write,
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [7:0] i_data_pins,
  output reg o_ce_n,
  output reg o_oe_n,
  output reg o_we_n,
  output reg [15:0] o_addr_lines,
  output reg [7:0] o_data_pins,
  output reg o_data_pins_oe,
  output reg [7:0] o_rdata,
  output reg o_done
);

localparam S_IDLE = 3'b001;
localparam S_SETUP = 3'b010;
localparam S_PULSE = 3'b100;

reg [2:0] state_q;
reg [7:0] cnt_q;
reg wr_q;

////////////////////////////////////////////////////////////////////////////////
// Select is held low across the cycle so the strobe edges define the load.
always @(posedge i_clock or posedge i_reset)
begin
  if (i_reset)
  begin
    state_q <= S_IDLE;
    cnt_q <= 8'h00;
    wr_q <= 1'b0;
    o_ce_n <= 1'b1;
    o_oe_n <= 1'b1;
    o_we_n <= 1'b1;
    o_addr_lines <= 16'h0000;
    o_data_pins <= 8'h00;
    o_data_pins_oe <= 1'b0;
    o_rdata <= 8'h00;
    o_done <= 1'b0;
  end
  else
  begin
    o_done <= 1'b0;
    case (state_q)
      S_IDLE:
      begin
        if (i_start)
        begin
          wr_q <= i_write;
          o_addr_lines <= i_addr; // R11
          o_data_pins <= i_wdata;
          o_ce_n <= 1'b0;
          cnt_q <= `PHASE_CYC;
          state_q <= S_SETUP;
        end
      end
      S_SETUP:
      begin
        cnt_q <= `PHASE_CYC;
        state_q <= S_PULSE;
        if (wr_q)
        begin
          o_oe_n <= 1'b1; // R4
          o_we_n <= 1'b0; // R4
          o_data_pins_oe <= 1'b1;
        end
        else
        begin
          o_oe_n <= 1'b0;
        end
      end
      S_PULSE:
      begin
        if (cnt_q == 8'h00)
        begin
          if (!wr_q)
            o_rdata <= i_data_pins;
          o_we_n <= 1'b1;
          o_oe_n <= 1'b1;
          o_ce_n <= 1'b1;
          o_done <= 1'b1;
          state_q <= S_IDLE;
        end
        else
          cnt_q <= cnt_q - 8'h01;
      end
      default:
        state_q <= S_IDLE;
    endcase
    // Data is released only after the strobe rose, so the device latches it.
    if (state_q == S_IDLE && !i_start)
      o_data_pins_oe <= 1'b0;
  end
end

endmodule // flash_strobe

// >>> flash_host_monitor.sv
// Pin checks for the flash host controller.
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_host_monitor
#(
  parameter GAP_CYC = 50
)
(
  input wire i_clock,
  input wire i_reset,
  input wire i_req,
  input wire [1:0] i_cmd,
  input wire o_busy,
  input wire o_rvalid,
  input wire o_ce_n,
  input wire o_oe_n,
  input wire o_we_n,
  input wire [15:0] o_addr_lines,
  input wire [7:0] o_data_pins,
  input wire o_data_pins_oe
);
  reg [15:0] gap_q;
  // Saturates, so a long wait while busy never wraps into a short gap.
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      gap_q <= 16'h0000;
    else if (!o_busy || !o_we_n)
      gap_q <= 16'h0000;
    else if (gap_q != 16'hFFFF)
      gap_q <= gap_q + 16'h0001;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////
  strobe_gate_a: assert property (
    !o_we_n |-> o_oe_n && !o_ce_n && o_data_pins_oe)
    else $error("strobe low without select or data");
  read_cond_a: assert property (
    !o_oe_n |-> !o_ce_n && o_we_n && !o_data_pins_oe)
    else $error("gate low outside a read");
  addr_hold_a: assert property (
    !o_we_n && $past(!o_we_n) |-> $stable(o_addr_lines))
    else $error("address moved under strobe");
  data_hold_a: assert property (
    !o_we_n && $past(!o_we_n) |-> $stable(o_data_pins))
    else $error("data moved under strobe");
  select_first_a: assert property (
    $fell(o_we_n) |-> $past(!o_ce_n))
    else $error("strobe fell before select");
  strobe_width_a: assert property (
    $fell(o_we_n) |-> (!o_we_n) [*7] ##1 o_we_n)
    else $error("strobe width wrong");
  load_gap_a: assert property (
    $fell(o_we_n) |-> gap_q <= GAP_CYC)
    else $error("load gap too long");
  done_quiet_a: assert property (
    $fell(o_busy) |-> o_we_n && !o_data_pins_oe)
    else $error("bus held at completion");
  cover property (o_rvalid);
  cover property (i_req && !o_busy && i_cmd == `CMD_ENABLE);
  cover property ($fell(o_busy) && i_cmd == `CMD_PROG);
endmodule // flash_host_monitor

bind flash_host flash_host_monitor #(.GAP_CYC(GAP_CYC)) flash_host_monitor_i
(
  .i_clock(i_clock),
  .i_reset(i_reset),
  .i_req(i_req),
  .i_cmd(i_cmd),
  .o_busy(o_busy),
  .o_rvalid(o_rvalid),
  .o_ce_n(o_ce_n),
  .o_oe_n(o_oe_n),
  .o_we_n(o_we_n),
  .o_addr_lines(o_addr_lines),
  .o_data_pins(o_data_pins),
  .o_data_pins_oe(o_data_pins_oe)
);

// >>> flash_model.sv
// Behavioural model of the sector flash device.
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_model
#(
  parameter real T_LOAD = 600.0,
  parameter real T_PROG = 1500.0
)
(
  input wire i_ce_n,
  input wire i_oe_n,
  input wire i_we_n,
  input wire [15:0] i_addr_lines,
  input wire [7:0] i_data_pins,
  output wire [7:0] o_data_pins,
  output wire o_data_pins_oe
);
  logic [7:0] mem [0:65535];
  logic [15:0] qa [$];
  logic [7:0] qd [$];
  logic [15:0] a_q;
  logic [7:0] last_d = 8'h00;
  logic armed = 1'b0;
  logic prot = 1'b0;
  logic busy = 1'b0;
  logic tog = 1'b0;
  realtime t_rise = 0.0;
  realtime t_end = 0.0;
  wire wr_n = i_ce_n | i_we_n;
  wire rd = !i_ce_n && !i_oe_n && i_we_n;
  initial
    for (int i = 0; i < 65536; i++) mem[i] = i[15:8] ^ i[7:0];
  ////////////////////////////////////////////////////////////////////////
  // Armed only by a real fall, so power-up edges load nothing.
  always @(negedge wr_n)
    if (i_oe_n) {armed, a_q} = {1'b1, i_addr_lines};
  always @(posedge wr_n)
    if (armed)
    begin
      qa.push_back(a_q);
      qd.push_back(i_data_pins);
      t_rise = $realtime;
      armed = 1'b0;
    end
  function automatic logic prefix(input [7:0] d2);
    return qa.size() > 2 && qa[0] == `PROT_ADDR0 && qd[0] == `PROT_DATA_EN0
      && qa[1] == `PROT_ADDR1 && qd[1] == `PROT_DATA_EN1
      && qa[2] == `PROT_ADDR0 && qd[2] == d2;
  endfunction
  task automatic close_window();
    logic en;
    logic dis;
    int k;
    en = prefix(`PROT_DATA_EN2);
    dis = prefix(`PROT_DATA_DIS2);
    k = (en || dis) ? 3 : 0;
    if (en) prot = 1'b1;
    if (dis) prot = 1'b0;
    if (qa.size() > k)
    begin
      busy = 1'b1;
      t_end = $realtime + T_PROG;
      last_d = qd[qd.size() - 1];
      if (en || !prot)
      begin
        for (int i = 0; i < 128; i++) mem[{qa[k][15:7], i[6:0]}] = 8'hFF;
        for (int i = k; i < qa.size(); i++) mem[qa[i]] = qd[i];
      end
    end
    qa.delete();
    qd.delete();
  endtask
  always #10
  begin
    if (busy && $realtime >= t_end) busy = 1'b0;
    if (qa.size() > 0 && $realtime - t_rise > T_LOAD) close_window();
  end
  always @(negedge rd) if (busy) tog = ~tog;
  assign o_data_pins_oe = rd;
  assign o_data_pins = busy ? {~last_d[7], tog, last_d[5:0]}
    : mem[i_addr_lines];
endmodule // flash_model

// >>> flash_host_tb.sv
// Self-checking bench for the flash host and the device model.
`timescale 1ns/1ps
`include "flash_host_map.vh"
`define CHECK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("BAD t=%0t got %h want %h", $time, got, exp); \
    end \
  end
module flash_host_tb;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_req = 1'b0;
  logic [1:0] i_cmd = 2'h0;
  logic [15:0] i_addr = 16'h0000;
  logic i_protect = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wvalid = 1'b0;
  logic [7:0] last_q = 8'h00;
  wire [7:0] bus, o_rdata, h_dq, m_dq;
  wire [15:0] addr;
  wire o_busy, o_wready, o_rvalid, o_timeout, ce_n, oe_n, we_n, h_oe, m_oe;
  int n_errors = 0;
  int total_checks = 0;
  // A released bus shows the inverse of its last level.
  assign bus = h_oe ? h_dq : (m_oe ? m_dq : ~last_q);
  always @(posedge i_clock) if (h_oe || m_oe) last_q <= bus;
  always #2.5 i_clock = ~i_clock;
  flash_host #(.PROG_CYC(200), .GAP_CYC(50)) flash_host_i
  (
    .i_clock(i_clock), .i_reset(i_reset), .i_req(i_req), .i_cmd(i_cmd),
    .i_addr(i_addr), .i_protect(i_protect), .i_wdata(i_wdata),
    .i_wvalid(i_wvalid), .i_data_pins(bus), .o_busy(o_busy),
    .o_wready(o_wready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_timeout(o_timeout), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_addr_lines(addr), .o_data_pins(h_dq), .o_data_pins_oe(h_oe)
  );
  flash_model flash_model_i
  (
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr_lines(addr),
    .i_data_pins(bus), .o_data_pins(m_dq), .o_data_pins_oe(m_oe)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stall();
    n_errors++;
    $display("BAD t=%0t wait ran out", $time);
    wrap_up();
  endtask
  task automatic start(input [1:0] cmd, input [15:0] a);
    int k;
    for (k = 0; k < 50 && o_busy !== 1'b0; k++) @(negedge i_clock);
    if (k == 50) stall();
    {i_req, i_cmd, i_addr} = {1'b1, cmd, a};
    @(negedge i_clock);
    i_req = 1'b0;
  endtask
  task automatic rd(input [15:0] a, input [7:0] exp);
    int k;
    start(`CMD_READ, a);
    for (k = 0; k < 100 && o_rvalid !== 1'b1; k++) @(negedge i_clock);
    if (k == 100) stall();
    `CHECK(o_rdata, exp)
  endtask
  // Feeds bytes base^offset; the take flag looks one edge ahead.
  task automatic op(input [1:0] cmd, input [15:0] a, input p, input [7:0] b);
    int n;
    int k;
    logic take;
    n = 0;
    take = 1'b0;
    {i_protect, i_wdata, i_wvalid} = {p, b, cmd == `CMD_PROG};
    start(cmd, a);
    for (k = 0; k < 8000; k++)
    begin
      if (take)
      begin
        n++;
        i_wdata = b ^ n[7:0];
        i_wvalid = (n < 128);
      end
      take = i_wvalid && o_wready;
      if (o_busy === 1'b0 && !i_wvalid) break;
      @(negedge i_clock);
    end
    if (k == 8000) stall();
  endtask
  task automatic sector(input [8:0] s, input [7:0] b);
    rd({s, 7'h00}, b);
    rd({s, 7'h55}, b ^ 8'h55);
    rd({s, 7'h7F}, b ^ 8'h7F);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHECK({ce_n, oe_n, we_n, o_busy, h_oe}, 5'h1C)
    `CHECK(flash_model_i.prot, 1'b0)
  endtask
  task automatic t_read();
    rd(16'h1234, 8'h26);
    rd(16'hFF00, 8'hFF);
  endtask
  task automatic t_open();
    op(`CMD_PROG, 16'h0185, 1'b0, 8'h5A);
    `CHECK(o_timeout, 1'b0)
    `CHECK(flash_model_i.busy, 1'b0)
    sector(9'h003, 8'h5A);
    rd(16'h0200, 8'h02);
  endtask
  task automatic t_guarded();
    op(`CMD_ENABLE, 16'h0000, 1'b0, 8'h00);
    `CHECK(flash_model_i.prot, 1'b1)
    op(`CMD_PROG, 16'h0280, 1'b1, 8'h30);
    `CHECK(o_timeout, 1'b0)
    sector(9'h005, 8'h30);
  endtask
  task automatic t_rejected();
    op(`CMD_PROG, 16'h0280, 1'b0, 8'h31);
    `CHECK(o_timeout, 1'b0)
    `CHECK(flash_model_i.busy, 1'b0)
    sector(9'h005, 8'h30);
    `CHECK(flash_model_i.prot, 1'b1)
  endtask
  task automatic t_release();
    op(`CMD_DISABLE, 16'h0000, 1'b0, 8'h00);
    `CHECK(flash_model_i.prot, 1'b0)
    op(`CMD_PROG, 16'h02C0, 1'b0, 8'hC3);
    sector(9'h005, 8'hC3);
  endtask
  initial
  begin
    repeat (12) @(negedge i_clock);
    i_reset = 1'b0;
    t_reset();
    t_read();
    t_open();
    t_guarded();
    t_rejected();
    t_release();
    wrap_up();
  end
endmodule // flash_host_tb
